/* File: verilog/osc_ctrl_defines.svh */
// register offsets, field positions, reset values and timing counts for the oscillator control block
// assumes inclusion by bare name from package and design files
`ifndef OSC_CTRL_DEFINES_SVH
`define OSC_CTRL_DEFINES_SVH

// apb byte offsets
`define OFS_OSC_CONTROL        12'h000
`define OFS_OSC_CONTROL_CLEAR  12'h004
`define OFS_OSC_CONTROL_SET    12'h008
`define OFS_OSC_CONTROL_INVERT 12'h00C
`define OFS_RC_TUNING          12'h010
`define OFS_RC_TUNING_CLEAR    12'h014
`define OFS_RC_TUNING_SET      12'h018
`define OFS_RC_TUNING_INVERT   12'h01C

// control register field positions
`define POS_DIVISOR_HI    20
`define POS_DIVISOR_LO    19
`define POS_MULT_HI       18
`define POS_MULT_LO       16
`define POS_CURRENT_HI    14
`define POS_CURRENT_LO    12
`define POS_NEXT_HI       10
`define POS_NEXT_LO       8
`define POS_LOCK_SEL      7
`define POS_USB_LOCKED    6
`define POS_PLL_LOCKED    5
`define POS_SLEEP         4
`define POS_FAIL          3
`define POS_USB_RC        2
`define POS_SEC_EN        1
`define POS_SWITCH        0

// writable mask of the control register (divisor, mult, next, lock, sleep, usb rc, sec en, switch)
`define CTRL_WRITABLE_MASK 32'h001F0797
// writable mask of the tuning register
`define TUN_WRITABLE_MASK  32'h0000003F

// configuration word field positions
`define CFG1_DIVISOR_HI  13
`define CFG1_DIVISOR_LO  12
`define CFG1_MONITOR_BIT 15
`define CFG1_SEC_EN      5
`define CFG1_SOURCE_HI   2
`define CFG1_SOURCE_LO   0
`define CFG2_MULT_HI     6
`define CFG2_MULT_LO     4

// reset values
`define RST_TRIM 6'h00

// clock switch settle time in ns and derived cycles at 25 MHz
`define SWITCH_TIME_NS     200
`define CLK_PERIOD_NS      40
`define SWITCH_CYCLES      ((`SWITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: verilog/osc_ctrl_pkg.sv */
// types shared by the oscillator control block
// assumes osc_ctrl_defines.svh is on the include path
package osc_ctrl_pkg;
    `include "osc_ctrl_defines.svh"

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

    // configuration words loaded at reset
    typedef struct packed {
        logic [31:0] cfgWordOne;
        logic [31:0] cfgWordTwo;
    } config_type;

    // analog status inputs
    typedef struct packed {
        logic pllLocked;
        logic usbPllLocked;
        logic clockFail;
    } analog_status_type;

    // clock source codes
    typedef enum logic [2:0] {
        SRC_FAST_RC = 3'h0,
        SRC_RC_WITH_PLL = 3'h1,
        SRC_PRIMARY = 3'h2,
        SRC_PRIMARY_PLL = 3'h3,
        SRC_SECONDARY = 3'h4,
        SRC_LOW_POWER_RC = 3'h5,
        SRC_FAST_RC_DIV16 = 3'h6,
        SRC_FAST_RC_POSTDIV = 3'h7
    } source_type;

    // switch sequencer states
    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT = 2'b01,
        SW_DONE = 2'b10
    } switch_state_type;

    // clock control outputs to the analog side
    typedef struct packed {
        logic [1:0] periphBusDivisor;
        logic [2:0] pllMultiplier;
        logic [4:0] pllFactor;
        logic [3:0] divideRatio;
        logic [2:0] currentSourceSel;
        logic sleepOnWait;
        logic usbInternalRcSel;
        logic secondaryOscEnable;
        logic [5:0] rcTrim;
        logic switchPulse;
    } clk_ctrl_type;
endpackage

/* File: verilog/sync_two_ff.sv */
// two flip-flop synchroniser for a group of level inputs
// assumes the destination clock is mclk; reset clears the chain
`timescale 1ns/100ps
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstSync_b,
    // levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1Reg;

    // first stage read only by second stage
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            stage1Reg <= '0;
            syncOut <= '0;
        end else begin
            stage1Reg <= asyncIn;
            syncOut <= stage1Reg;
        end
    end
endmodule

/* File: verilog/osc_ctrl.sv */
// oscillator control and tuning registers behind an apb slave
// assumes config words stable around reset release; analog status pins asynchronous
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "osc_ctrl_defines.svh"

// Notes on behaviour
// - divisor code gives bus clock ratio 1,2,4,8
// - divisor loads from config word one
// - multiplier code selects factor 15..21, 24
// - multiplier loads from config word two
// - current source field is read-only status
// - both source fields load from boot config
// - reserved bits written zero, read as zero
// - lock bit holds selections only with monitor
// - usb pll locked status bit reported
// - system pll locked status bit reported
// - sleep bit chooses sleep or idle
// - fail flag set on detected clock failure
// - usb clock source select bit
// - secondary oscillator enable bit
// - secondary enable loads from config word one
// - switch bit self-clears when switch completes
// - clear alias clears written ones
// - set alias sets written ones
// - invert alias toggles written ones
// - tuning register has clear, set, invert aliases
module osc_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // configuration words
    input wire osc_ctrl_pkg::config_type cfg,
    // analog status, asynchronous
    input wire osc_ctrl_pkg::analog_status_type anaStatus,
    // apb slave
    input wire osc_ctrl_pkg::apb_req_type apbReq,
    output osc_ctrl_pkg::apb_rsp_type apbRsp,
    // clock control outputs
    output osc_ctrl_pkg::clk_ctrl_type clkCtrl
);
    import osc_ctrl_pkg::*;

    // whole module state
    typedef struct packed {
        logic [1:0] divisor;
        logic [2:0] mult;
        logic [2:0] current;
        logic [2:0] next;
        logic lockSel;
        logic sleep;
        logic fail;
        logic usbRc;
        logic secEn;
        logic switchReq;
        logic [5:0] trim;
        switch_state_type swState;
        logic [7:0] swCount;
        logic loaded;
        logic monitorOn;
        apb_rsp_type rsp;
        clk_ctrl_type ctrl;
    } state_type;

    state_type stateReg;
    state_type stateNext;
    logic rstMetaReg;
    logic rstSync_b;
    analog_status_type statusSync;

    // reset release through two flip-flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstMetaReg <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMetaReg <= 1'b1;
            rstSync_b <= rstMetaReg;
        end
    end

    // status pins synchronised before use
    sync_two_ff #(
        .WIDTH(3)
    ) statusSyncInst (
        .mclk(mclk),
        .rstSync_b(rstSync_b),
        .asyncIn(anaStatus),
        .syncOut(statusSync)
    );

    // pll factor from multiplier code
    function automatic logic [4:0] factorOf(input logic [2:0] code);
        logic [4:0] f;
        f = 5'h0F;
        case (code)
            3'h6: f = 5'h15;
            3'h7: f = 5'h18;
            default: f = 5'h0F + {2'b00, code};
        endcase
        return f;
    endfunction

    // divide ratio from divisor code
    function automatic logic [3:0] ratioOf(input logic [1:0] code);
        logic [3:0] r;
        r = 4'h1 << code;
        return r;
    endfunction

    // control register image for reads
    function automatic logic [31:0] ctrlImage(input state_type s, input analog_status_type st);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`POS_DIVISOR_HI:`POS_DIVISOR_LO] = s.divisor;
        v[`POS_MULT_HI:`POS_MULT_LO] = s.mult;
        v[`POS_CURRENT_HI:`POS_CURRENT_LO] = s.current;
        v[`POS_NEXT_HI:`POS_NEXT_LO] = s.next;
        v[`POS_LOCK_SEL] = s.lockSel;
        v[`POS_USB_LOCKED] = st.usbPllLocked;
        v[`POS_PLL_LOCKED] = st.pllLocked;
        v[`POS_SLEEP] = s.sleep;
        v[`POS_FAIL] = s.fail;
        v[`POS_USB_RC] = s.usbRc;
        v[`POS_SEC_EN] = s.secEn;
        v[`POS_SWITCH] = s.switchReq;
        return v;
    endfunction

    // next state of the whole block
    always_comb begin
        logic [31:0] cur;
        logic [31:0] upd;
        logic [31:0] tcur;
        logic [31:0] tupd;
        logic locked;
        logic hit;
        logic ctrlWr;
        logic tunWr;
        logic failWr;
        cur = ctrlImage(stateReg, statusSync);
        upd = cur;
        tcur = {26'h0000000, stateReg.trim};
        tupd = tcur;
        locked = stateReg.monitorOn & stateReg.lockSel;
        hit = apbReq.psel & apbReq.penable;
        ctrlWr = 1'b0;
        tunWr = 1'b0;
        failWr = 1'b1;
        stateNext = stateReg;
        stateNext.rsp.pready = 1'b0;
        stateNext.rsp.pslverr = 1'b0;
        stateNext.ctrl.switchPulse = 1'b0;

        // config load once after reset release
        if (!stateReg.loaded) begin
            stateNext.loaded = 1'b1;
            stateNext.divisor = cfg.cfgWordOne[`CFG1_DIVISOR_HI:`CFG1_DIVISOR_LO];
            stateNext.mult = cfg.cfgWordTwo[`CFG2_MULT_HI:`CFG2_MULT_LO];
            stateNext.current = cfg.cfgWordOne[`CFG1_SOURCE_HI:`CFG1_SOURCE_LO];
            stateNext.next = cfg.cfgWordOne[`CFG1_SOURCE_HI:`CFG1_SOURCE_LO];
            stateNext.secEn = cfg.cfgWordOne[`CFG1_SEC_EN];
            stateNext.monitorOn = cfg.cfgWordOne[`CFG1_MONITOR_BIT];
        end else begin
            // apb access phase, answered in one cycle
            if (hit && !stateReg.rsp.pready) begin
                stateNext.rsp.pready = 1'b1;
                stateNext.rsp.prdata = 32'h0000_0000;
                case (apbReq.paddr)
                    `OFS_OSC_CONTROL: begin
                        upd = apbReq.pwdata;
                        ctrlWr = apbReq.pwrite;
                        stateNext.rsp.prdata = cur;
                    end
                    `OFS_OSC_CONTROL_CLEAR: begin
                        upd = cur & ~apbReq.pwdata;
                        ctrlWr = apbReq.pwrite;
                    end
                    `OFS_OSC_CONTROL_SET: begin
                        upd = cur | apbReq.pwdata;
                        ctrlWr = apbReq.pwrite;
                    end
                    `OFS_OSC_CONTROL_INVERT: begin
                        upd = cur ^ apbReq.pwdata;
                        ctrlWr = apbReq.pwrite;
                    end
                    `OFS_RC_TUNING: begin
                        tupd = apbReq.pwdata;
                        tunWr = apbReq.pwrite;
                        stateNext.rsp.prdata = tcur;
                    end
                    `OFS_RC_TUNING_CLEAR: begin
                        tupd = tcur & ~apbReq.pwdata;
                        tunWr = apbReq.pwrite;
                    end
                    `OFS_RC_TUNING_SET: begin
                        tupd = tcur | apbReq.pwdata;
                        tunWr = apbReq.pwrite;
                    end
                    `OFS_RC_TUNING_INVERT: begin
                        tupd = tcur ^ apbReq.pwdata;
                        tunWr = apbReq.pwrite;
                    end
                    default: begin
                        stateNext.rsp.pslverr = 1'b1;
                    end
                endcase
            end

            // fail bit may only be cleared by software, so keep its written value apart
            failWr = upd[`POS_FAIL];
            // only writable bits change; reserved and read-only bits kept
            upd = (upd & `CTRL_WRITABLE_MASK) | (cur & ~`CTRL_WRITABLE_MASK);
            if (ctrlWr) begin
                stateNext.divisor = upd[`POS_DIVISOR_HI:`POS_DIVISOR_LO];
                stateNext.sleep = upd[`POS_SLEEP];
                stateNext.usbRc = upd[`POS_USB_RC];
                stateNext.secEn = upd[`POS_SEC_EN];
                stateNext.lockSel = upd[`POS_LOCK_SEL];
                // selections frozen while locked
                if (!locked) begin
                    stateNext.mult = upd[`POS_MULT_HI:`POS_MULT_LO];
                    stateNext.next = upd[`POS_NEXT_HI:`POS_NEXT_LO];
                    if (upd[`POS_SWITCH] && stateReg.swState == SW_IDLE) begin
                        stateNext.switchReq = 1'b1;
                    end
                end
            end
            if (tunWr) begin
                stateNext.trim = tupd[5:0];
            end

            // clock fail is sticky; a detection wins over a software clear
            if (ctrlWr) begin
                stateNext.fail = stateReg.fail & failWr;
            end
            if (statusSync.clockFail) begin
                stateNext.fail = 1'b1;
            end

            // switch sequencer
            case (stateReg.swState)
                SW_IDLE: begin
                    if (stateReg.switchReq) begin
                        stateNext.swState = SW_WAIT;
                        stateNext.swCount = 8'(`SWITCH_CYCLES);
                        stateNext.ctrl.switchPulse = 1'b1;
                    end
                end
                SW_WAIT: begin
                    if (stateReg.swCount <= 8'h01) begin
                        stateNext.swState = SW_DONE;
                    end else begin
                        stateNext.swCount = stateReg.swCount - 8'h01;
                    end
                end
                SW_DONE: begin
                    stateNext.current = stateReg.next;
                    stateNext.switchReq = 1'b0;
                    stateNext.swState = SW_IDLE;
                end
                default: begin
                    stateNext.swState = SW_IDLE;
                end
            endcase
        end

        // registered clock control outputs
        stateNext.ctrl.periphBusDivisor = stateNext.divisor;
        stateNext.ctrl.divideRatio = ratioOf(stateNext.divisor);
        stateNext.ctrl.pllMultiplier = stateNext.mult;
        stateNext.ctrl.pllFactor = factorOf(stateNext.mult);
        stateNext.ctrl.currentSourceSel = stateNext.current;
        stateNext.ctrl.sleepOnWait = stateNext.sleep;
        stateNext.ctrl.usbInternalRcSel = stateNext.usbRc;
        stateNext.ctrl.secondaryOscEnable = stateNext.secEn;
        stateNext.ctrl.rcTrim = stateNext.trim;
    end

    // state register
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            stateReg <= '0;
            stateReg.trim <= `RST_TRIM;
            stateReg.swState <= SW_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign apbRsp = stateReg.rsp;
    assign clkCtrl = stateReg.ctrl;
endmodule

/* File: verif/osc_ctrl_assertions.sv */
// checker for apb timing and clock control outputs of osc_ctrl
// assumes it is bound to osc_ctrl and sees only its ports
`timescale 1ns/100ps
module osc_ctrl_assertions (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // watched ports
    input wire osc_ctrl_pkg::config_type cfg,
    input wire osc_ctrl_pkg::analog_status_type anaStatus,
    input wire osc_ctrl_pkg::apb_req_type apbReq,
    input wire osc_ctrl_pkg::apb_rsp_type apbRsp,
    input wire osc_ctrl_pkg::clk_ctrl_type clkCtrl
);
    import osc_ctrl_pkg::*;
    logic tunWrite;
    logic ctrlWrite;
    logic [5:0] trimExp_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // completed writes to the tuning and control groups
    assign tunWrite = apbRsp.pready && apbReq.pwrite && apbReq.paddr[11:4] == 8'h01;
    assign ctrlWrite = apbRsp.pready && apbReq.pwrite && apbReq.paddr[11:4] == 8'h00;

    // trim value expected after a tuning write
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trimExp_reg <= 6'h00;
        end else if (tunWrite) begin
            case (apbReq.paddr[3:2])
                2'h0: trimExp_reg <= apbReq.pwdata[5:0];
                2'h1: trimExp_reg <= trimExp_reg & ~apbReq.pwdata[5:0];
                2'h2: trimExp_reg <= trimExp_reg | apbReq.pwdata[5:0];
                default: trimExp_reg <= trimExp_reg ^ apbReq.pwdata[5:0];
            endcase
        end
    end

    a_ready_latency: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready)
        else $error("ready not one cycle after access");
    a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (apbRsp.pready |-> apbRsp.pslverr == (apbReq.paddr > 12'h01C))
        else $error("error response wrong for address");
    a_prdata_hold: assert property (!apbRsp.pready |-> $stable(apbRsp.prdata))
        else $error("read data moved outside an answer");
    a_reserved_zero: assert property (apbRsp.pready && !apbReq.pwrite && apbReq.paddr == 12'h000
        |-> apbRsp.prdata[31:21] == 11'h000 && !apbRsp.prdata[15] && !apbRsp.prdata[11])
        else $error("reserved control bits read nonzero");
    a_alias_zero: assert property (apbRsp.pready && !apbReq.pwrite && apbReq.paddr[11:5] == 7'h00
        && apbReq.paddr[3:2] != 2'h0 |-> apbRsp.prdata == 32'h0000_0000)
        else $error("alias read nonzero");
    a_divide_ratio: assert property (clkCtrl.divideRatio != 4'h0
        |-> clkCtrl.divideRatio == (4'h1 << clkCtrl.periphBusDivisor))
        else $error("bus divide ratio wrong");
    a_pll_factor: assert property (clkCtrl.pllFactor != 5'h00 |-> clkCtrl.pllFactor ==
        (clkCtrl.pllMultiplier == 3'h7 ? 5'h18 : 5'h0F + clkCtrl.pllMultiplier))
        else $error("pll factor wrong");
    a_switch_cause: assert property (clkCtrl.switchPulse |-> $past(ctrlWrite) || $past(ctrlWrite, 2))
        else $error("switch pulse without control write");
    a_switch_pulse: assert property (clkCtrl.switchPulse |=> !clkCtrl.switchPulse)
        else $error("switch pulse too long");
    a_trim_update: assert property (tunWrite |-> ##[1:2] clkCtrl.rcTrim == trimExp_reg)
        else $error("trim output not updated");
endmodule

bind osc_ctrl osc_ctrl_assertions u_chk (.mclk(mclk), .rst_b(rst_b), .cfg(cfg), .anaStatus(anaStatus),
    .apbReq(apbReq), .apbRsp(apbRsp), .clkCtrl(clkCtrl));

/* File: verif/oscillator_control_registers_tb_top.sv */
// self-checking bench for the oscillator control registers
// assumes osc_ctrl and its checker are compiled before it
`timescale 1ns/100ps
module oscillator_control_registers_tb_top;
    import osc_ctrl_pkg::*;
    localparam int W = 32'h001F0796;
    localparam int LK = 32'h00070701;
    logic mclk;
    logic rst_b;
    config_type cfg;
    analog_status_type anaStatus;
    apb_req_type apbReq;
    apb_rsp_type apbRsp;
    clk_ctrl_type clkCtrl;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int pulses = 0;
    int mc;
    int mt;
    logic mon;
    logic [31:0] seed = 32'h7F85;

    osc_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .cfg(cfg), .anaStatus(anaStatus), .apbReq(apbReq),
        .apbRsp(apbRsp), .clkCtrl(clkCtrl));

    // clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog and switch pulse count
    always @(posedge mclk) begin
        cycles++;
        if (clkCtrl.switchPulse === 1'b1) pulses++;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer, held until ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
        @(posedge mclk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        do @(posedge mclk); while (apbRsp.pready !== 1'b1);
        r = {apbRsp.pslverr, apbRsp.prdata};
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctrl_exp();
        return 32'(mc) | {25'h0, anaStatus.usbPllLocked, anaStatus.pllLocked, 5'h00};
    endfunction

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] e);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(name, 64'(r), {32'h0, e});
    endtask

    // model update then write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [32:0] r;
        int m;
        m = (mon && mc[7]) ? W & ~LK : W;
        case (a[4:2])
            3'h0: mc = (mc & ~m) | (d & m);
            3'h1: mc = mc & ~(d & m);
            3'h2: mc = mc | (d & m);
            3'h3: mc = mc ^ (d & m);
            3'h4: mt = d & 32'h3F;
            3'h5: mt = mt & ~d;
            3'h6: mt = (mt | d) & 32'h3F;
            default: mt = (mt ^ d) & 32'h3F;
        endcase
        apb(1'b1, a, d, r);
        chk("write response", 64'(r[32]), 64'h0);
    endtask

    task automatic outchk();
        int dv;
        int mu;
        dv = (mc >> 19) & 3;
        mu = (mc >> 16) & 7;
        chk("outputs", {clkCtrl.periphBusDivisor, clkCtrl.divideRatio, clkCtrl.pllMultiplier, clkCtrl.pllFactor,
            clkCtrl.currentSourceSel, clkCtrl.sleepOnWait, clkCtrl.usbInternalRcSel, clkCtrl.secondaryOscEnable,
            clkCtrl.rcTrim}, {2'(dv), 4'(1 << dv), 3'(mu), 5'(mu == 7 ? 24 : 15 + mu), 3'(mc >> 12),
            1'(mc >> 4), 1'(mc >> 2), 1'(mc >> 1), 6'(mt)});
    endtask

    task automatic do_reset(input logic [31:0] c1, input logic [31:0] c2);
        rst_b <= 1'b0;
        cfg <= '{cfgWordOne: c1, cfgWordTwo: c2};
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (8) @(posedge mclk);
        mon = c1[15];
        mc = (int'(c1[13:12]) << 19) | (int'(c2[6:4]) << 16) | (int'(c1[2:0]) * 32'h1100) | (int'(c1[5]) << 1);
        mt = 0;
    endtask

    // main sequence
    initial begin
        logic [32:0] r;
        logic [31:0] v;
        rst_b = 1'b0;
        cfg = '0;
        anaStatus = '0;
        apbReq = '0;
        for (int i = 0; i < 4; i++) begin
            do_reset(rnd() & ~32'h8000, rnd());
            rdchk("control after reset", 12'h000, ctrl_exp());
            rdchk("tuning after reset", 12'h010, 32'h0);
            outchk();
        end
        $display("test reset load done");
        for (int i = 0; i < 40; i++) begin
            v = rnd();
            anaStatus <= '{pllLocked: v[0], usbPllLocked: v[1], clockFail: 1'b0};
            wr(12'(v[4:2] * 4), v[4] ? rnd() & 32'h3F : rnd() & ~32'h8881);
            repeat (4) @(posedge mclk);
            rdchk("control", 12'h000, ctrl_exp());
            rdchk("tuning", 12'h010, 32'(mt));
            outchk();
        end
        for (int i = 1; i < 8; i++) begin
            if (i != 4) rdchk("alias read", 12'(i * 4), 32'h0);
        end
        apb(1'b1, 12'h040, 32'hFFFF_FFFF, r);
        chk("unmapped write", 64'(r[32]), 64'h1);
        apb(1'b0, 12'h100, 32'h0, r);
        chk("unmapped read", 64'(r[32]), 64'h1);
        rdchk("control kept", 12'h000, ctrl_exp());
        $display("test aliases done");
        anaStatus.clockFail <= 1'b1;
        repeat (5) @(posedge mclk);
        anaStatus.clockFail <= 1'b0;
        mc = mc | 8;
        rdchk("fail flag set", 12'h000, ctrl_exp());
        apb(1'b1, 12'h004, 32'h8, r);
        mc = mc & ~8;
        rdchk("fail flag cleared", 12'h000, ctrl_exp());
        $display("test clock fail done");
        for (int k = 0; k < 8; k++) begin
            mc = (mc & ~32'h700) | (k << 8);
            apb(1'b1, 12'h000, 32'(mc) | 32'h1, r);
            rdchk("switch pending", 12'h000, ctrl_exp() | 32'h1);
            repeat (10) @(posedge mclk);
            mc = (mc & ~32'h7000) | (k << 12);
            rdchk("switch done", 12'h000, ctrl_exp());
            chk("switch pulses", 64'(pulses), 64'(k + 1));
            outchk();
        end
        $display("test switch done");
        for (int m = 0; m < 2; m++) begin
            do_reset({16'h0, m[0], 15'h0} | (rnd() & 32'h3027), rnd());
            wr(12'h008, 32'h80);
            wr(12'h00C, 32'h00070710);
            rdchk("locked fields", 12'h000, ctrl_exp());
            wr(12'h004, 32'h80);
            wr(12'h00C, 32'h00070700);
            rdchk("unlocked fields", 12'h000, ctrl_exp());
        end
        $display("test lock done");
        end_sim();
    end
endmodule
